//--- hw/scp_port.v
/*
  Device side of the clocked serial command and status port. The host
  serial clock is oversampled on sys_clk; commands are collected into bytes,
  channel status is shifted out, and the status and error pins are driven.
  Assumes the host serial clock is well below a quarter of sys_clk and that
  the playback core supplies per-channel busy and request levels on sys_clk.
*/
// Notes on behaviour
// - With edge select low, input is captured on rising and output changed on falling edges.
// - With edge select high, input is captured on falling and output changed on rising edges.
// - Serial clock and data are only accepted while chip select is low.
// - While selected, the status of each channel is shifted out one bit per serial clock.
// - The serial output is released to high impedance whenever chip select is high.
// - The status-select command picks busy or next-data-request for the channel status pin.
// - The error pin is high while an error condition exists and low otherwise.
// - In reset or power-down the status pin is 1, error 0 and serial output released.
// - The command-busy output is low while a command is processed; the host waits for high.
// - Reset returns the port to its initial state and it then sits in power-down.
`timescale 1ns/1ps
`include "scp_defines.vh"
module scp_port #(
  parameter CHANNELS = `SCP_CH_COUNT
) (
  input wire sys_clk,
  input wire resetn,
  input wire edge_polarity_select,
  input wire chip_select_low,
  input wire serial_clk,
  input wire serial_in,
  input wire power_up,
  input wire [CHANNELS-1:0] channel_busy_n,
  input wire [CHANNELS-1:0] channel_next_data_request,
  input wire error_event,
  input wire cmd_done,
  output reg serial_out,
  output reg serial_out_en,
  output reg channel_status,
  output reg error_flag,
  output reg command_busy_n,
  output reg [`SCP_CMD_BITS-1:0] cmd_byte,
  output reg cmd_valid,
  output reg status_sel_req
);
  localparam ST_DOWN = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_BUSY = 2'h2;

  wire [3:0] pins_sync;
  reg [1:0] state;
  reg sck_prev;
  reg [`SCP_CNT_W-1:0] bit_cnt;
  reg [`SCP_CMD_BITS-1:0] shift_in;
  reg [CHANNELS-1:0] shift_out;
  reg [`SCP_BUSY_W-1:0] busy_cnt;
  reg [1:0] ch_idx;

  wire pol = pins_sync[0];
  wire cs_n = ~pins_sync[1];
  wire sck = pins_sync[2];
  wire sdi = pins_sync[3];
  wire rise = sck & ~sck_prev;
  wire fall = ~sck & sck_prev;
  wire selected = ~cs_n && state != ST_DOWN;
  wire cap_edge = selected && (pol ? fall : rise);
  wire lau_edge = selected && (pol ? rise : fall);
  wire [`SCP_CMD_BITS-1:0] next_byte = {shift_in[`SCP_CMD_BITS-2:0], sdi};
  wire byte_done = cap_edge && bit_cnt == `SCP_CNT_LAST;

  // Chip select enters the synchroniser inverted, so its reset value reads as deselected.
  scp_sync #(.WIDTH(4)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .din({serial_in, serial_clk, ~chip_select_low, edge_polarity_select}),
    .dout(pins_sync)
  );

  // Decides whether a completed byte is the status-select command.
  function is_status_sel;
    input [`SCP_CMD_BITS-1:0] b;
    begin
      is_status_sel = b[`SCP_CMD_OP_MSB:`SCP_CMD_OP_LSB] == `SCP_OP_STATUS_SEL;
    end
  endfunction

  // Busy lasts the minimum count and then until the core reports done. A
  // command abandoned by power-down ends on the count alone, so the host is
  // never locked out after the next power-up.
  wire busy_release = !command_busy_n && busy_cnt == {`SCP_BUSY_W{1'b0}} &&
    (cmd_done || state != ST_BUSY);
  // Reset levels show on the pins from the edge at which power_up drops.
  wire pins_idle = state == ST_DOWN || !power_up;

  // Power and command state.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_DOWN;
    end else begin
      case (state)
        ST_DOWN: begin
          // Power-down leaves the port deaf to the serial pins until woken.
          if (power_up) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!power_up) begin
            state <= ST_DOWN;
          end else if (byte_done) begin
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          // A byte taken while busy restarts the count and keeps the port busy.
          if (!power_up) begin
            state <= ST_DOWN;
          end else if (busy_release && !byte_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_DOWN;
        end
      endcase
    end
  end

  // Serial input: command bytes collect on capture edges, MSB first.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sck_prev <= 1'b0;
      bit_cnt <= `SCP_CNT_ZERO;
      shift_in <= {`SCP_CMD_BITS{1'b0}};
      cmd_byte <= {`SCP_CMD_BITS{1'b0}};
      cmd_valid <= 1'b0;
    end else begin
      sck_prev <= sck;
      cmd_valid <= byte_done;
      if (!selected) begin
        // A deselect or power-down drops any partial byte, so frames restart clean.
        bit_cnt <= `SCP_CNT_ZERO;
      end else if (cap_edge) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (cap_edge) begin
        shift_in <= next_byte;
      end
      if (byte_done) begin
        cmd_byte <= next_byte;
      end
    end
  end

  // Only the status-select command is decoded here; the rest go to the core.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_sel_req <= `SCP_SEL_BUSY;
    end else if (byte_done && is_status_sel(next_byte)) begin
      status_sel_req <= next_byte[`SCP_SEL_BIT];
    end
  end

  // Command-busy handshake toward the host.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      command_busy_n <= 1'b1;
      busy_cnt <= {`SCP_BUSY_W{1'b0}};
    end else if (byte_done) begin
      command_busy_n <= 1'b0;
      busy_cnt <= `SCP_BUSY_CYCLES;
    end else if (busy_cnt != {`SCP_BUSY_W{1'b0}}) begin
      busy_cnt <= busy_cnt - 4'h1;
    end else if (busy_release) begin
      command_busy_n <= 1'b1;
    end
  end

  // Serial status output.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_out <= {CHANNELS{1'b0}};
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
    end else if (pins_idle) begin
      serial_out_en <= 1'b0;
    end else begin
      serial_out_en <= ~cs_n;
      if (cs_n) begin
        // The first capture edge of a frame comes before any launch edge, so
        // the first status bit is put out while the port is still deselected.
        serial_out <= ~channel_busy_n[CHANNELS-1];
        shift_out <= {~channel_busy_n[CHANNELS-2:0], ~channel_busy_n[CHANNELS-1]};
      end else if (lau_edge) begin
        serial_out <= shift_out[CHANNELS-1];
        shift_out <= {shift_out[CHANNELS-2:0], shift_out[CHANNELS-1]};
      end
    end
  end

  // Status and error pins.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      channel_status <= `SCP_STATUS_RESET;
      error_flag <= `SCP_ERR_RESET;
      ch_idx <= 2'h0;
    end else begin
      // The rotation index is two bits wide, so it covers four channels.
      ch_idx <= ch_idx + 2'h1;
      if (pins_idle) begin
        channel_status <= `SCP_STATUS_RESET;
        error_flag <= `SCP_ERR_RESET;
      end else begin
        error_flag <= error_event;
        // The status pin shows one channel per cycle in rotation.
        if (status_sel_req == `SCP_SEL_REQ) begin
          channel_status <= channel_next_data_request[ch_idx];
        end else begin
          channel_status <= channel_busy_n[ch_idx];
        end
      end
    end
  end
endmodule

//--- hw/scp_defines.vh
/*
  Constants for the serial command and status port: frame size, command
  codes, status selection and reset values of the pins.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH
`define SCP_CMD_BITS 8
`define SCP_CH_COUNT 4
`define SCP_CNT_W 3
`define SCP_CNT_LAST 3'h7
`define SCP_CNT_ZERO 3'h0
`define SCP_CMD_OP_MSB 7
`define SCP_CMD_OP_LSB 4
`define SCP_OP_STATUS_SEL 4'h9
`define SCP_SEL_BIT 0
`define SCP_SEL_BUSY 1'h0
`define SCP_SEL_REQ 1'h1
`define SCP_STATUS_RESET 1'h1
`define SCP_ERR_RESET 1'h0
`define SCP_BUSY_CYCLES 4'h4
`define SCP_BUSY_W 4
`endif

//--- hw/scp_sync.v
/*
  Two-flop synchroniser for a vector of asynchronous pin levels.
  Assumes the inputs are levels that stay stable over several sys_clk cycles.
*/
`timescale 1ns/1ps
module scp_sync #(
  parameter WIDTH = 4
) (
  input wire sys_clk,
  input wire resetn,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule

//--- tb/scp_port_props.sv
/* Assertions on the pins of scp_port.
   Assumes one sys_clk domain and the port names of scp_port. */
`timescale 1ns/1ps
module scp_port_props (
  input wire sys_clk,
  input wire resetn,
  input wire chip_select_low,
  input wire power_up,
  input wire error_event,
  input wire cmd_valid,
  input wire [7:0] cmd_byte,
  input wire command_busy_n,
  input wire status_sel_req,
  input wire serial_out_en,
  input wire channel_status,
  input wire error_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_busy_min;
    !command_busy_n[*4];
  endsequence
  a_pdown_pins: assert property (!power_up[*2] |->
    channel_status && !error_flag && !serial_out_en) else $error("pins not idle");
  a_cs_hiz: assert property (chip_select_low[*4] |-> !serial_out_en)
    else $error("output driven while deselected");
  a_err_track: assert property (power_up[*3] |->
    error_flag == $past(error_event)) else $error("error pin off");
  a_valid_once: assert property (cmd_valid |=> !cmd_valid)
    else $error("long valid");
  a_busy_hold: assert property (cmd_valid |-> s_busy_min)
    else $error("busy too short");
  a_busy_cause: assert property ($fell(command_busy_n) |-> cmd_valid)
    else $error("busy without command");
  a_sel_set: assert property (cmd_valid && cmd_byte[7:4] == 4'h9 |->
    ##2 status_sel_req == $past(cmd_byte[0], 2)) else $error("select not taken");
  a_sel_keep: assert property (!cmd_valid |-> $stable(status_sel_req))
    else $error("select moved");
endmodule
bind scp_port scp_port_props u_props (.*);

//--- tb/scp_host.sv
/* Host model that shifts command bytes into the port.
   Assumes sys_clk paces the serial clock at five cycles a phase. */
`timescale 1ns/1ps
module scp_host (
  input wire sys_clk,
  input wire pol,
  input wire so,
  output reg csn,
  output reg sck,
  output reg sdi
);
  initial begin
    csn = 1'h1;
    sck = 1'h0;
    sdi = 1'h0;
  end
  task half;
    begin
      repeat (5) @(posedge sys_clk);
      #1 sck = !sck;
    end
  endtask
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      #1 sck = pol;
      repeat (5) @(posedge sys_clk);
      #1 csn = 1'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        sdi = tx[i];
        half;
        rx[i] = so;
        half;
      end
      csn = 1'h1;
      // No pull on the data line, so a released line must not look valid.
      sdi = !sdi;
    end
  endtask
endmodule

//--- tb/testbench.sv
/* Self-checking bench for scp_port driven by the host model.
   Assumes the design files under hw/. */
`timescale 1ns/1ps
module testbench;
  reg sys_clk = 1'h0, resetn = 1'h0, pol = 1'h0, pwr = 1'h0, err = 1'h0, done = 1'h0;
  reg [3:0] bsy_n = 4'hf, req = 4'h0;
  reg [7:0] rx, got;
  wire csn, sck, sdi, so, en, st, ef, cbn, val, sel;
  wire [7:0] cb;
  // The serial output has no pull, so a released line shows the inverse level.
  wire so_pin = en ? so : !so;
  integer err_count = 0, total_checks = 0, i;
  scp_port u_dut (.sys_clk(sys_clk), .resetn(resetn), .edge_polarity_select(pol),
    .chip_select_low(csn), .serial_clk(sck), .serial_in(sdi), .power_up(pwr),
    .channel_busy_n(bsy_n), .channel_next_data_request(req), .error_event(err),
    .cmd_done(done), .serial_out(so), .serial_out_en(en), .channel_status(st),
    .error_flag(ef), .command_busy_n(cbn), .cmd_byte(cb), .cmd_valid(val),
    .status_sel_req(sel));
  scp_host u_host (.sys_clk(sys_clk), .pol(pol), .so(so_pin), .csn(csn), .sck(sck), .sdi(sdi));
  initial forever #4 sys_clk = !sys_clk;
  always @(posedge sys_clk) if (val) got <= cb;
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wrap_up;
    begin
      if (err_count == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 resetn = 1'h1;
    chk("reset pins", {st, ef, en, cbn}, 8'h9);
    pwr = 1'h1;
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge sys_clk);
      #1 pol = i[0];
      bsy_n = i ? 4'h0 : 4'ha;
      req = 4'hf;
      repeat (6) @(posedge sys_clk);
      u_host.xfer(i ? 8'h90 : 8'h91, rx);
      chk("status bits", rx, i ? 8'hff : 8'h55);
      chk("command", got, i ? 8'h90 : 8'h91);
      repeat (6) @(posedge sys_clk);
      #1 chk("release", {en, cbn}, 8'h0);
      done = 1'h1;
      repeat (3) @(posedge sys_clk);
      #1 done = 1'h0;
      chk("select", {sel, cbn}, i ? 8'h1 : 8'h3);
      chk("channel pin", st, i == 0);
    end
    err = 1'h1;
    repeat (2) @(posedge sys_clk);
    #1 chk("error pin", ef, 8'h1);
    err = 1'h0;
    pwr = 1'h0;
    repeat (3) @(posedge sys_clk);
    #1 chk("power down", {st, ef, en}, 8'h4);
    wrap_up;
  end
  initial begin
    #20000;
    err_count = err_count + 1;
    wrap_up;
  end
endmodule
